// ==== timing_params.svh ====
`ifndef TIMING_PARAMS_SVH
`define TIMING_PARAMS_SVH

// ********************************************
// Per-cycle state costs by access location
// ********************************************
`define COST_FETCH_ONCHIP 2
`define COST_FETCH_REGFIELD 6
`define COST_FETCH_EXT_BASE 6
`define COST_BYTE_ONCHIP 2
`define COST_BYTE_REGFIELD 3
`define COST_BYTE_EXT_BASE 3
`define COST_WORD_ONCHIP 2
`define COST_WORD_REGFIELD 6
`define COST_WORD_EXT_BASE 6
`define COST_INTERNAL 1

// ********************************************
// Cycle counts per instruction class
// ********************************************
`define CNT_FETCH_SHORT 1
`define CNT_FETCH_LONG 2
`define CNT_BYTE_TEST 1
`define CNT_BYTE_RMW 2

// ********************************************
// Default widths
// ********************************************
`define DEFAULT_WAIT_W 3
`define DEFAULT_COUNT_W 8

`endif

// ==== timing_pkg.sv ====
package timing_pkg;

  // ********************************************
  // Types
  // ********************************************

  // Where a bus cycle lands.
  typedef enum logic [1:0] {
    LOC_ONCHIP_MEM = 2'h0,
    LOC_REG_FIELD = 2'h1,
    LOC_EXTERNAL = 2'h2
  } access_loc_t;

  // Instruction classes whose cycle mix is known to this block.
  typedef enum logic [2:0] {
    CLS_ALU_REG = 3'h0,
    CLS_BRANCH_REL8 = 3'h1,
    CLS_BIT_AND_REG = 3'h2,
    CLS_BIT_AND_MEM = 3'h3,
    CLS_BIT_CLEAR_REG = 3'h4,
    CLS_BIT_CLEAR_MEM = 3'h5
  } instr_class_t;

  // Number of cycles of each type in one instruction.
  typedef struct packed {
    logic [1:0] fetch;
    logic [1:0] branchRead;
    logic [1:0] stack;
    logic [1:0] byteAccess;
    logic [1:0] wordAccess;
    logic [1:0] internalOp;
  } cycle_counts_t;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOOKUP = 4'b0010,
    ST_SUM = 4'b0100,
    ST_RUN = 4'b1000
  } seq_state_t;

endpackage

// ==== cost_if.sv ====
`timescale 1ns/1ps
`default_nettype none

// Carries access locations in and per-cycle costs out of the cost table.
interface cost_if import timing_pkg::*; #(
  parameter int WAIT_W = 3,
  parameter int COUNT_W = 8
);
  access_loc_t fetchLoc;
  access_loc_t stackLoc;
  access_loc_t dataLoc;
  logic [WAIT_W-1:0] waitStates;
  logic [COUNT_W-1:0] fetchCost;
  logic [COUNT_W-1:0] branchCost;
  logic [COUNT_W-1:0] stackCost;
  logic [COUNT_W-1:0] byteCost;
  logic [COUNT_W-1:0] wordCost;
  logic [COUNT_W-1:0] internalCost;

  modport table_side (
    input fetchLoc, stackLoc, dataLoc, waitStates,
    output fetchCost, branchCost, stackCost, byteCost, wordCost, internalCost
  );
  modport user_side (
    output fetchLoc, stackLoc, dataLoc, waitStates,
    input fetchCost, branchCost, stackCost, byteCost, wordCost, internalCost
  );
endinterface

`default_nettype wire

// ==== cycle_cost_table.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timing_params.svh"

module cycle_cost_table import timing_pkg::*; #(
  parameter int WAIT_W = `DEFAULT_WAIT_W,
  parameter int COUNT_W = `DEFAULT_COUNT_W
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Locations in, costs out.
  cost_if.table_side costs
);

  // ********************************************
  // Cost of one cycle
  // ********************************************

  // External cost is base plus m, or base plus 2m for fetch-sized cycles.
  function automatic logic [COUNT_W-1:0] costOf(input access_loc_t loc, input logic [WAIT_W-1:0] m,
                                                input int onchip, input int regField,
                                                input int extBase, input logic doubled);
    logic [COUNT_W-1:0] waitPart;
    waitPart = doubled ? COUNT_W'({m, 1'b0}) : COUNT_W'(m);
    unique case (loc)
      LOC_ONCHIP_MEM: costOf = COUNT_W'(onchip);
      LOC_REG_FIELD: costOf = COUNT_W'(regField);
      LOC_EXTERNAL: costOf = COUNT_W'(extBase) + waitPart;
      default: costOf = COUNT_W'(extBase) + waitPart; // Unused code treated as slowest.
    endcase
  endfunction

  logic [COUNT_W-1:0] next_fetchCost;
  logic [COUNT_W-1:0] next_stackCost;
  logic [COUNT_W-1:0] next_byteCost;
  logic [COUNT_W-1:0] next_wordCost;

  // Next costs from the current locations and wait count.
  always_comb begin
    next_fetchCost = costOf(costs.fetchLoc, costs.waitStates, `COST_FETCH_ONCHIP,
                            `COST_FETCH_REGFIELD, `COST_FETCH_EXT_BASE, 1'b1);
    // Stack cycles cost what a fetch to the same place costs.
    next_stackCost = costOf(costs.stackLoc, costs.waitStates, `COST_FETCH_ONCHIP,
                            `COST_FETCH_REGFIELD, `COST_FETCH_EXT_BASE, 1'b1);
    next_byteCost = costOf(costs.dataLoc, costs.waitStates, `COST_BYTE_ONCHIP,
                           `COST_BYTE_REGFIELD, `COST_BYTE_EXT_BASE, 1'b0);
    next_wordCost = costOf(costs.dataLoc, costs.waitStates, `COST_WORD_ONCHIP,
                           `COST_WORD_REGFIELD, `COST_WORD_EXT_BASE, 1'b1);
  end

  // Registered so the adder tree in the sequencer sees stable operands.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      costs.fetchCost <= '0;
      costs.branchCost <= '0;
      costs.stackCost <= '0;
      costs.byteCost <= '0;
      costs.wordCost <= '0;
      costs.internalCost <= '0;
    end else begin
      costs.fetchCost <= next_fetchCost;
      costs.branchCost <= next_fetchCost; // Vector reads go where fetches go.
      costs.stackCost <= next_stackCost;
      costs.byteCost <= next_byteCost;
      costs.wordCost <= next_wordCost;
      costs.internalCost <= COUNT_W'(`COST_INTERNAL); // No bus, so no location or wait.
    end
  end

endmodule // cycle_cost_table

`default_nettype wire

// ==== instruction_state_count_timing.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "timing_params.svh"

module instruction_state_count_timing import timing_pkg::*; #(
  parameter int WAIT_W = `DEFAULT_WAIT_W,
  parameter int COUNT_W = `DEFAULT_COUNT_W
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Instruction request.
  input wire logic start,
  input wire instr_class_t instrClass,
  input wire access_loc_t fetchLoc,
  input wire access_loc_t stackLoc,
  input wire access_loc_t dataLoc,
  input wire logic [WAIT_W-1:0] waitStates,
  // Execution status.
  output logic busy,
  output logic done,
  output logic illegalClass,
  output logic [COUNT_W-1:0] totalStates,
  output logic [COUNT_W-1:0] statesLeft
);

  // ********************************************
  // Elaboration checks
  // ********************************************

  // Worst case is two fetches and two byte accesses at the largest wait count.
  localparam int WORST = 2 * (`COST_FETCH_EXT_BASE + 2 * ((1 << WAIT_W) - 1))
                       + 2 * (`COST_BYTE_EXT_BASE + ((1 << WAIT_W) - 1));
  if (WAIT_W < 1 || WAIT_W > 8) begin : g_bad_wait
    $error("WAIT_W must lie between 1 and 8");
  end
  if (COUNT_W > 16 || WORST >= (1 << COUNT_W)) begin : g_bad_count
    $error("COUNT_W cannot hold the worst-case state total");
  end

  // ********************************************
  // Cycle mix per class
  // ********************************************

  // Illegal codes return all zeros; the caller flags them.
  function automatic cycle_counts_t countsOf(input instr_class_t cls);
    countsOf = '0;
    unique case (cls)
      CLS_ALU_REG: countsOf.fetch = 2'(`CNT_FETCH_SHORT);
      CLS_BRANCH_REL8: countsOf.fetch = 2'(`CNT_FETCH_LONG); // Taken or not.
      CLS_BIT_AND_REG, CLS_BIT_CLEAR_REG: countsOf.fetch = 2'(`CNT_FETCH_SHORT);
      CLS_BIT_AND_MEM: begin
        countsOf.fetch = 2'(`CNT_FETCH_LONG);
        countsOf.byteAccess = 2'(`CNT_BYTE_TEST);
      end
      CLS_BIT_CLEAR_MEM: begin
        countsOf.fetch = 2'(`CNT_FETCH_LONG);
        countsOf.byteAccess = 2'(`CNT_BYTE_RMW); // Read then write back.
      end
      default: countsOf = '0;
    endcase
  endfunction

  // One term of the weighted sum.
  function automatic logic [COUNT_W-1:0] weigh(input logic [1:0] count, input logic [COUNT_W-1:0] cost);
    logic [COUNT_W+1:0] product;
    product = {{COUNT_W{1'b0}}, count} * {2'b00, cost};
    weigh = product[COUNT_W-1:0];
  endfunction

  function automatic logic isKnown(input instr_class_t cls);
    unique case (cls)
      CLS_ALU_REG, CLS_BRANCH_REL8, CLS_BIT_AND_REG, CLS_BIT_AND_MEM,
      CLS_BIT_CLEAR_REG, CLS_BIT_CLEAR_MEM: isKnown = 1'b1;
      default: isKnown = 1'b0;
    endcase
  endfunction

  // ********************************************
  // Cost table
  // ********************************************

  cost_if #(.WAIT_W(WAIT_W), .COUNT_W(COUNT_W)) costs ();

  cycle_cost_table #(.WAIT_W(WAIT_W), .COUNT_W(COUNT_W)) u_cost_table (
    .clock(clock),
    .rstn(rstn),
    .costs(costs)
  );

  // ********************************************
  // Sequencer
  // ********************************************

  seq_state_t state, next_state;
  cycle_counts_t counts, next_counts;
  access_loc_t fetchLocHeld, next_fetchLocHeld;
  access_loc_t stackLocHeld, next_stackLocHeld;
  access_loc_t dataLocHeld, next_dataLocHeld;
  logic [WAIT_W-1:0] waitHeld, next_waitHeld;
  logic next_busy;
  logic next_done;
  logic next_illegalClass;
  logic [COUNT_W-1:0] next_totalStates;
  logic [COUNT_W-1:0] next_statesLeft;
  logic [COUNT_W-1:0] weightedSum;

  // Held request feeds the table so a changing input cannot skew the costs.
  assign costs.fetchLoc = fetchLocHeld;
  assign costs.stackLoc = stackLocHeld;
  assign costs.dataLoc = dataLocHeld;
  assign costs.waitStates = waitHeld;

  // Execution states as the sum of every count weighted by its cost.
  assign weightedSum = weigh(counts.fetch, costs.fetchCost)
                     + weigh(counts.branchRead, costs.branchCost)
                     + weigh(counts.stack, costs.stackCost)
                     + weigh(counts.byteAccess, costs.byteCost)
                     + weigh(counts.wordAccess, costs.wordCost)
                     + weigh(counts.internalOp, costs.internalCost);

  // Next-state logic; a start while busy is ignored.
  always_comb begin
    next_state = state;
    next_counts = counts;
    next_fetchLocHeld = fetchLocHeld;
    next_stackLocHeld = stackLocHeld;
    next_dataLocHeld = dataLocHeld;
    next_waitHeld = waitHeld;
    next_busy = busy;
    next_done = 1'b0;
    next_illegalClass = illegalClass;
    next_totalStates = totalStates;
    next_statesLeft = statesLeft;
    unique case (state)
      ST_IDLE: begin
        if (start) begin
          next_illegalClass = !isKnown(instrClass);
          if (isKnown(instrClass)) begin
            next_counts = countsOf(instrClass);
            next_fetchLocHeld = fetchLoc;
            next_stackLocHeld = stackLoc;
            next_dataLocHeld = dataLoc;
            next_waitHeld = waitStates;
            next_busy = 1'b1;
            next_state = ST_LOOKUP;
          end else begin
            next_totalStates = '0;
            next_done = 1'b1;
          end
        end
      end
      ST_LOOKUP: begin
        next_state = ST_SUM;
      end
      ST_SUM: begin
        next_totalStates = weightedSum;
        next_statesLeft = weightedSum;
        next_state = ST_RUN;
      end
      ST_RUN: begin
        // One clock is spent per state; the last one raises done.
        next_statesLeft = statesLeft - COUNT_W'(1);
        if (statesLeft == COUNT_W'(1)) begin
          next_busy = 1'b0;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // Registers only.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      counts <= '0;
      fetchLocHeld <= LOC_ONCHIP_MEM;
      stackLocHeld <= LOC_ONCHIP_MEM;
      dataLocHeld <= LOC_ONCHIP_MEM;
      waitHeld <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      illegalClass <= 1'b0;
      totalStates <= '0;
      statesLeft <= '0;
    end else begin
      state <= next_state;
      counts <= next_counts;
      fetchLocHeld <= next_fetchLocHeld;
      stackLocHeld <= next_stackLocHeld;
      dataLocHeld <= next_dataLocHeld;
      waitHeld <= next_waitHeld;
      busy <= next_busy;
      done <= next_done;
      illegalClass <= next_illegalClass;
      totalStates <= next_totalStates;
      statesLeft <= next_statesLeft;
    end
  end

endmodule // instruction_state_count_timing

`default_nettype wire

// ==== mem_side_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Memory map model
// ****************
module mem_side_model import timing_pkg::*; (
  // Map select, data in bits 3:2, fetch in 1:0.
  input wire logic [3:0] mode,
  // Access locations.
  output var access_loc_t fetchLoc,
  output var access_loc_t stackLoc,
  output var access_loc_t dataLoc
);
  // The stack shares the data space, so one select sets both.
  always_comb begin
    fetchLoc = access_loc_t'(mode[1:0]);
    dataLoc = access_loc_t'(mode[3:2]);
    stackLoc = dataLoc;
  end
endmodule // mem_side_model
`default_nettype wire

// ==== timing_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module timing_chk import timing_pkg::*; #(parameter int WAIT_W = 3, parameter int COUNT_W = 8) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Request.
  input wire logic start,
  input wire instr_class_t instrClass,
  input wire access_loc_t fetchLoc,
  input wire access_loc_t stackLoc,
  input wire access_loc_t dataLoc,
  input wire logic [WAIT_W-1:0] waitStates,
  // Status.
  input wire logic busy,
  input wire logic done,
  input wire logic illegalClass,
  input wire logic [COUNT_W-1:0] totalStates,
  input wire logic [COUNT_W-1:0] statesLeft
);
  // **************
  // Helper logic
  // **************
  wire logic taken;
  wire logic legal;
  int fc;
  int bc;
  logic [COUNT_W-1:0] want, next_want, span, next_span;
  assign taken = start && !busy;
  assign legal = instrClass <= CLS_BIT_CLEAR_MEM;
  // Expected total is latched when a request is taken.
  always_comb begin
    fc = fetchLoc == LOC_ONCHIP_MEM ? 2 : fetchLoc == LOC_REG_FIELD ? 6 : 6 + 2 * waitStates;
    bc = dataLoc == LOC_ONCHIP_MEM ? 2 : dataLoc == LOC_REG_FIELD ? 3 : 3 + waitStates;
    next_want = want;
    next_span = busy ? span + 1'b1 : span;
    if (taken) begin
      next_span = '0;
      case (instrClass)
        CLS_BRANCH_REL8: next_want = COUNT_W'(2 * fc);
        CLS_BIT_AND_MEM: next_want = COUNT_W'(2 * fc + bc);
        CLS_BIT_CLEAR_MEM: next_want = COUNT_W'(2 * fc + 2 * bc);
        default: next_want = COUNT_W'(fc);
      endcase
    end
  end
  // Registers only.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      want <= '0;
      span <= '0;
    end else begin
      want <= next_want;
      span <= next_span;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  property p_accept; taken && legal |=> busy && !done; endproperty
  a_accept: assert property (p_accept) else $error("busy missing");
  property p_illegal; taken && !legal |=> done && illegalClass && !busy && totalStates == '0; endproperty
  a_illegal: assert property (p_illegal) else $error("bad class answer");
  property p_alu; taken && instrClass == CLS_ALU_REG && fetchLoc == LOC_ONCHIP_MEM |-> ##3 totalStates == 2; endproperty
  a_alu: assert property (p_alu) else $error("alu total");
  property p_total; taken && legal |-> ##3 totalStates == want; endproperty
  a_total: assert property (p_total) else $error("total wrong");
  property p_span; done && !illegalClass |-> span == totalStates + 2; endproperty
  a_span: assert property (p_span) else $error("run length");
  property p_drain; done && !illegalClass |-> statesLeft == '0 && !busy; endproperty
  a_drain: assert property (p_drain) else $error("not drained");
  property p_hold; busy && $past(busy) && $past(busy, 2) && $past(busy, 3) |-> $stable(totalStates); endproperty
  a_hold: assert property (p_hold) else $error("total moved");
  property p_flag; !$past(taken) |-> $stable(illegalClass); endproperty
  a_flag: assert property (p_flag) else $error("flag moved");
  c_bad: cover property (taken && !legal);
  c_end: cover property (done && !illegalClass);
  c_b2b: cover property (taken && done);
endmodule // timing_chk
bind instruction_state_count_timing timing_chk #(.WAIT_W(WAIT_W), .COUNT_W(COUNT_W)) chk_u (.clock(clock),
  .rstn(rstn), .start(start), .instrClass(instrClass), .fetchLoc(fetchLoc), .stackLoc(stackLoc), .dataLoc(dataLoc),
  .waitStates(waitStates), .busy(busy), .done(done), .illegalClass(illegalClass), .totalStates(totalStates),
  .statesLeft(statesLeft));
`default_nettype wire

// ==== instruction_state_count_timing_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module instruction_state_count_timing_tb import timing_pkg::*;;
  // **************
  // Bench
  // **************
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  instr_class_t instrClass = CLS_ALU_REG;
  logic [3:0] mode = 4'h0;
  logic [2:0] waitStates = 3'h0;
  access_loc_t fetchLoc, stackLoc, dataLoc;
  logic busy, done, illegalClass;
  logic [7:0] totalStates, statesLeft;
  int err_count = 0;
  int samples_checked = 0;
  // Clock of 10 ns.
  always #5 clock = ~clock;
  instruction_state_count_timing dut_u (.clock(clock), .rstn(rstn), .start(start), .instrClass(instrClass),
    .fetchLoc(fetchLoc), .stackLoc(stackLoc), .dataLoc(dataLoc), .waitStates(waitStates), .busy(busy),
    .done(done), .illegalClass(illegalClass), .totalStates(totalStates), .statesLeft(statesLeft));
  mem_side_model far_u (.mode(mode), .fetchLoc(fetchLoc), .stackLoc(stackLoc), .dataLoc(dataLoc));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Bounded wait so a lost done cannot hang the run.
  task automatic wait_done(output int n);
    n = 0;
    while (done !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
  endtask
  task automatic issue(input instr_class_t c, input logic [3:0] md, input logic [2:0] m);
    @(negedge clock);
    start = 1'b1;
    instrClass = c;
    mode = md;
    waitStates = m;
    @(negedge clock);
  endtask
  // Run length is the total plus two cycles, one in ST_LOOKUP and one in ST_SUM.
  task automatic run(input instr_class_t c, input logic [3:0] md, input logic [2:0] m, input logic [7:0] e);
    int n;
    issue(c, md, m);
    start = 1'b0;
    wait_done(n);
    check(totalStates, e);
    check(8'(n), e + 8'h02);
    check(statesLeft, 8'h00);
  endtask
  task automatic t_alu;
    run(CLS_ALU_REG, 4'h0, 3'h3, 8'h02);
    run(CLS_ALU_REG, 4'h1, 3'h3, 8'h06);
    run(CLS_ALU_REG, 4'h3, 3'h7, 8'h14);
    $display("alu test over");
  endtask
  task automatic t_branch;
    run(CLS_BRANCH_REL8, 4'h1, 3'h0, 8'h0c);
    run(CLS_BRANCH_REL8, 4'hc, 3'h2, 8'h04);
    run(CLS_BRANCH_REL8, 4'h2, 3'h7, 8'h28);
    $display("branch test over");
  endtask
  task automatic t_bit;
    run(CLS_BIT_AND_REG, 4'h9, 3'h4, 8'h06);
    run(CLS_BIT_AND_MEM, 4'h4, 3'h0, 8'h07);
    run(CLS_BIT_CLEAR_REG, 4'h8, 3'h5, 8'h02);
    run(CLS_BIT_CLEAR_MEM, 4'ha, 3'h1, 8'h18);
    $display("bit test over");
  endtask
  // Both unused class codes answer at once and leave no total.
  task automatic t_illegal;
    for (int k = 6; k < 8; k++) begin
      issue(instr_class_t'(k[2:0]), 4'h0, 3'h0);
      start = 1'b0;
      check({5'h00, done, illegalClass, busy}, 8'h06);
      check(totalStates, 8'h00);
    end
    run(CLS_ALU_REG, 4'h0, 3'h0, 8'h02);
    check({7'h00, illegalClass}, 8'h00);
    $display("illegal test over");
  endtask
  // Start held high: refused while busy, taken again in the cycle that done is high.
  task automatic t_b2b;
    int n;
    issue(CLS_BRANCH_REL8, 4'h1, 3'h0);
    instrClass = CLS_ALU_REG;
    mode = 4'h0;
    wait_done(n);
    check(totalStates, 8'h0c);
    check(8'(n), 8'h0e);
    @(negedge clock);
    start = 1'b0;
    check({7'h00, busy}, 8'h01);
    wait_done(n);
    check(totalStates, 8'h02);
    $display("back to back test over");
  endtask
  task automatic close_out;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence after six cycles of reset.
  initial begin
    repeat (6) @(negedge clock);
    rstn = 1'b1;
    t_alu();
    t_branch();
    t_bit();
    t_illegal();
    t_b2b();
    close_out();
  end
  // Tests need well under a thousand cycles.
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule // instruction_state_count_timing_tb
`default_nettype wire
